// ==== bkc_buck_ctrl.sv ====
// step-down converter control with an AHB-Lite register slave
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

`include "bkc_cfg.svh"

module bkc_buck_ctrl #(
    parameter int unsigned SS_CYCLES = `BKC_SS_CYCLES,
    parameter logic [6:0]  VSEL_RST  = `BKC_VSEL_RST
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output var  logic [31:0]       hrdata,
    output var  logic              hreadyout,
    output var  logic              hresp,
    // power request pins
    input  wire bkc_pkg::bkc_req_t req_pins,
    // analog side inputs
    input  wire logic              pg_comp_raw,
    input  wire logic [6:0]        duty_demand,
    input  wire logic              light_load,
    input  wire logic              pfm_burst_request,
    // converter outputs
    output var  logic              converter_enable,
    output var  logic [12:0]       target_mv,
    output var  logic [12:0]       pg_threshold_mv,
    output var  logic              forced_pwm,
    output var  logic              psave_active,
    output var  bkc_pkg::bkc_drive_t drive,
    // interrupt
    output var  logic              irq
);

    localparam logic [10:0] SS_LAST = 11'(SS_CYCLES);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic        acc_ok;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic        rd_pend;
    logic [7:0]  rd_idx;
    logic [7:0]  addr_idx;
    logic        addr_in_map;

    // a transfer is taken only on a non-idle address phase with hready high
    assign acc_ok      = hsel & htrans[1] & hready;
    assign addr_idx    = haddr[9:2];
    assign addr_in_map = (haddr[31:10] == 22'h000000);

    // hsize is ignored: only whole-word accesses are expected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx  <= 8'h00;
            rd_pend <= 1'b0;
            rd_idx  <= 8'h00;
        end else begin
            wr_pend <= acc_ok & hwrite;
            rd_pend <= acc_ok & ~hwrite;
            if (acc_ok) begin
                wr_idx <= addr_in_map ? addr_idx : 8'hFF;
                rd_idx <= addr_in_map ? addr_idx : 8'hFF;
            end
        end
    end

    // reads take one wait state so read data always come from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= ~(acc_ok & ~hwrite);
            hresp     <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    bkc_pkg::bkc_vsel_t          vsel;
    logic                        mode_fpwm;
    logic                        sw_on;
    logic [`BKC_IRQ_W-1:0]       irq_mask;
    logic [`BKC_IRQ_W-1:0]       irq_stat;
    logic                        wr_vsel;
    logic                        wr_mode;
    logic                        wr_ctrl;
    logic                        wr_mask;

    assign wr_vsel = wr_pend & (wr_idx == `BKC_IDX_VSEL);
    assign wr_mode = wr_pend & (wr_idx == `BKC_IDX_MODE);
    assign wr_ctrl = wr_pend & (wr_idx == `BKC_IDX_CTRL);
    assign wr_mask = wr_pend & (wr_idx == `BKC_IDX_IRQ_MASK);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vsel      <= VSEL_RST;
            mode_fpwm <= `BKC_MODE_RST;
            sw_on     <= `BKC_ON_RST;
            irq_mask  <= `BKC_MASK_RST;
        end else begin
            if (wr_vsel) begin
                vsel <= hwdata[`BKC_VSEL_RANGE_BIT:0];
            end
            if (wr_mode) begin
                mode_fpwm <= hwdata[`BKC_MODE_FPWM_BIT];
            end
            if (wr_ctrl) begin
                sw_on <= hwdata[`BKC_CTRL_ON_BIT];
            end
            if (wr_mask) begin
                irq_mask <= hwdata[`BKC_IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // voltage decode
    // ----------------------------------------------------------------
    logic [12:0] dec_mv;
    logic        dec_avail;
    logic [12:0] held_mv;
    logic        vsel_wr_d1;
    logic        vsel_wr_d2;

    bkc_vdec u_vdec (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .vsel        (vsel),
        .level_mv    (dec_mv),
        .level_avail (dec_avail)
    );

    // an unavailable code keeps the last good level rather than collapsing the rail
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_mv    <= 13'h0000;
            vsel_wr_d1 <= 1'b0;
            vsel_wr_d2 <= 1'b0;
        end else begin
            vsel_wr_d1 <= wr_vsel;
            vsel_wr_d2 <= vsel_wr_d1;
            if (dec_avail) begin
                held_mv <= dec_mv;
            end
        end
    end

    // ----------------------------------------------------------------
    // enable sequence
    // ----------------------------------------------------------------
    bkc_pkg::bkc_state_t state;
    bkc_pkg::bkc_state_t next_state;
    logic                req_any;
    logic                en_req;
    logic [10:0]         ramp_cnt;
    logic                ramp_end;

    // any request pin asks for the converter
    assign req_any  = req_pins.handsfree_power_request | req_pins.power_key_request
                    | req_pins.power_hold_request;
    assign en_req   = req_any & sw_on;
    assign ramp_end = (ramp_cnt == SS_LAST);

    always_comb begin
        next_state = state;
        case (state)
            bkc_pkg::BKC_OFF: begin
                if (en_req) begin
                    next_state = bkc_pkg::BKC_RAMP;
                end
            end
            bkc_pkg::BKC_RAMP: begin
                if (!en_req) begin
                    next_state = bkc_pkg::BKC_OFF;
                end else if (ramp_end) begin
                    next_state = bkc_pkg::BKC_RUN;
                end
            end
            bkc_pkg::BKC_RUN: begin
                if (!en_req) begin
                    next_state = bkc_pkg::BKC_OFF;
                end
            end
            default: begin
                next_state = bkc_pkg::BKC_OFF;
            end
        endcase
    end

    // ramp counter restarts from zero on every enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= bkc_pkg::BKC_OFF;
            ramp_cnt <= 11'h000;
        end else begin
            state <= next_state;
            if (next_state != bkc_pkg::BKC_RAMP) begin
                ramp_cnt <= 11'h000;
            end else if (!ramp_end) begin
                ramp_cnt <= ramp_cnt + 11'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // regulation target and power-good threshold
    // ----------------------------------------------------------------
    logic [23:0] ramp_prod;
    logic [12:0] next_target;
    logic [22:0] pg_prod;

    // target climbs linearly across the ramp, and falls whenever a lower level is selected
    assign ramp_prod   = 24'(held_mv) * 24'(ramp_cnt);
    // target falls to zero at the same edge as the enable, so off never shows a level
    assign next_target = (next_state == bkc_pkg::BKC_OFF) ? 13'h0000
                       : (state != bkc_pkg::BKC_RUN) ? 13'(ramp_prod / 24'(SS_CYCLES))
                       : held_mv;
    // threshold sits about 6 percent under the held level, which the target reaches only in run
    assign pg_prod     = 23'(held_mv) * 23'(`BKC_PG_NUM);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target_mv        <= 13'h0000;
            pg_threshold_mv  <= 13'h0000;
            converter_enable <= 1'b0;
        end else begin
            target_mv        <= next_target;
            pg_threshold_mv  <= 13'(pg_prod >> `BKC_PG_SHIFT);
            converter_enable <= (next_state != bkc_pkg::BKC_OFF);
        end
    end

    // ----------------------------------------------------------------
    // power good
    // ----------------------------------------------------------------
    logic pg_meta;
    logic pg_sync;
    logic pg_ok;
    logic next_pg_ok;

    // forced low while off or ramping
    // clears when the comparator sees the output low
    assign next_pg_ok = (state == bkc_pkg::BKC_RUN) & pg_sync;

    // two flops before the comparator is used
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pg_meta <= 1'b0;
            pg_sync <= 1'b0;
            pg_ok   <= 1'b0;
        end else begin
            pg_meta <= pg_comp_raw;
            pg_sync <= pg_meta;
            pg_ok   <= next_pg_ok;
        end
    end

    // ----------------------------------------------------------------
    // switching timebase and drive
    // ----------------------------------------------------------------
    logic [6:0]  tb_phase;
    logic [7:0]  tb_sum;
    logic        tb_wrap;
    logic        duty_full;
    logic        sw_active;
    logic        next_psave;
    logic        next_high;

    // fractional phase, 8 of 125 per clock gives 1.6 MHz from 25 MHz
    assign tb_sum    = 8'(tb_phase) + 8'(`BKC_TB_STEP);
    assign tb_wrap   = (tb_sum >= 8'(`BKC_TB_MOD));
    assign duty_full = (duty_demand >= 7'(`BKC_TB_MOD));
    assign sw_active = (state != bkc_pkg::BKC_OFF);
    // power save only when not forced and load is light
    assign next_psave = sw_active & ~mode_fpwm & light_load;
    // outside power save, full duty holds the high side with no off gap
    assign next_high  = sw_active & (next_psave ? pfm_burst_request
                                   : (duty_full | (tb_phase < duty_demand)));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tb_phase <= 7'h00;
        end else begin
            tb_phase <= tb_wrap ? 7'(tb_sum - 8'(`BKC_TB_MOD)) : tb_sum[6:0];
        end
    end

    // synchronous rectifier conducts when the high side is off, except while off or in power save
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive        <= '0;
            forced_pwm   <= 1'b0;
            psave_active <= 1'b0;
        end else begin
            drive.high_side_on <= next_high;
            drive.low_side_on  <= sw_active & ~next_high & ~next_psave;
            drive.cycle_start  <= tb_wrap;
            forced_pwm         <= mode_fpwm;
            psave_active       <= next_psave;
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    logic [`BKC_IRQ_W-1:0] irq_evt;
    logic [`BKC_IRQ_W-1:0] irq_clr;
    logic [`BKC_IRQ_W-1:0] next_stat;

    assign irq_evt[`BKC_IRQ_PG_RISE]  = next_pg_ok & ~pg_ok;
    assign irq_evt[`BKC_IRQ_PG_FALL]  = ~next_pg_ok & pg_ok;
    assign irq_evt[`BKC_IRQ_SS_DONE]  = (state == bkc_pkg::BKC_RAMP)
                                      & (next_state == bkc_pkg::BKC_RUN);
    assign irq_evt[`BKC_IRQ_BAD_CODE] = vsel_wr_d2 & ~dec_avail;
    assign irq_clr   = (rd_pend && rd_idx == `BKC_IDX_IRQ_STAT) ? '1 : '0;
    // a new event beats the read-clear in the same cycle
    assign next_stat = (irq_stat & ~irq_clr) | irq_evt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_stat;
            irq      <= |(next_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;

    // unused bits are read only and read zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (rd_idx)
            `BKC_IDX_VSEL:     rd_mux[`BKC_VSEL_RANGE_BIT:0] = vsel;
            `BKC_IDX_MODE:     rd_mux[`BKC_MODE_FPWM_BIT]    = mode_fpwm;
            `BKC_IDX_CTRL: begin
                rd_mux[`BKC_CTRL_ON_BIT] = sw_on;
                rd_mux[`BKC_CTRL_OK_BIT] = pg_ok;
            end
            `BKC_IDX_IRQ_STAT: rd_mux[`BKC_IRQ_W-1:0] = irq_stat;
            `BKC_IDX_IRQ_MASK: rd_mux[`BKC_IRQ_W-1:0] = irq_mask;
            default:           rd_mux = 32'h00000000;
        endcase
    end

    // captured in the wait cycle of each read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend) begin
            hrdata <= rd_mux;
        end
    end

endmodule

`default_nettype wire

// ==== bkc_cfg.svh ====
// offsets, field positions, reset values and timing counts of the buck control block
`ifndef BKC_CFG_SVH
`define BKC_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define BKC_IDX_VSEL       8'h14
`define BKC_IDX_MODE       8'h15
`define BKC_IDX_SPARE      8'h16
`define BKC_IDX_CTRL       8'h17
`define BKC_IDX_IRQ_STAT   8'h18
`define BKC_IDX_IRQ_MASK   8'h19

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BKC_VSEL_CODE_MSB  5
`define BKC_VSEL_RANGE_BIT 6
`define BKC_MODE_FPWM_BIT  0
`define BKC_CTRL_ON_BIT    0
`define BKC_CTRL_OK_BIT    1
`define BKC_IRQ_PG_RISE    0
`define BKC_IRQ_PG_FALL    1
`define BKC_IRQ_SS_DONE    2
`define BKC_IRQ_BAD_CODE   3
`define BKC_IRQ_W          4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BKC_VSEL_RST       7'h4B
`define BKC_MODE_RST       1'h0
`define BKC_ON_RST         1'h1
`define BKC_MASK_RST       4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BKC_CLK_PERIOD_NS  40
`define BKC_SS_TIME_NS     80000
`define BKC_SS_CYCLES      ((`BKC_SS_TIME_NS + `BKC_CLK_PERIOD_NS - 1) / `BKC_CLK_PERIOD_NS)
`define BKC_TB_STEP        8
`define BKC_TB_MOD         125
`define BKC_PG_NUM         963
`define BKC_PG_SHIFT       10

`endif

// ==== bkc_pkg.sv ====
// types shared by the buck control block
package bkc_pkg;

    // external power request pins
    typedef struct packed {
        logic handsfree_power_request;
        logic power_key_request;
        logic power_hold_request;
    } bkc_req_t;

    // voltage selection register contents
    typedef struct packed {
        logic       voltage_range_select;
        logic [5:0] voltage_select_code;
    } bkc_vsel_t;

    // switch drive bundle
    typedef struct packed {
        logic high_side_on;
        logic low_side_on;
        logic cycle_start;
    } bkc_drive_t;

    // converter sequence
    typedef enum logic [1:0] {
        BKC_OFF  = 2'b00,
        BKC_RAMP = 2'b01,
        BKC_RUN  = 2'b10
    } bkc_state_t;

endpackage

// ==== bkc_vdec.sv ====
// voltage code decoder: range bit and six-bit code to a level in millivolts
`timescale 1ns/1ps
`default_nettype none

module bkc_vdec (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // selection in
    input  wire bkc_pkg::bkc_vsel_t vsel,
    // decoded level out
    output var  logic [12:0]       level_mv,
    output var  logic              level_avail
);

    logic [1:0]  col;
    logic [3:0]  row;
    logic [12:0] next_mv;
    logic        next_avail;

    assign col = vsel.voltage_select_code[5:4];
    assign row = vsel.voltage_select_code[3:0];

    // ----------------------------------------------------------------
    // decode table
    // ----------------------------------------------------------------
    // range decode table
    always_comb begin
        next_mv    = 13'h0000;
        next_avail = 1'b1;
        if (vsel.voltage_range_select) begin
            next_mv = 13'd1250 + 13'(vsel.voltage_select_code) * 13'd50;
        end else begin
            case (col)
                2'b00: begin
                    next_avail = 1'b0;
                end
                2'b01: begin
                    // odd 5 mV jump at the middle row
                    next_avail = (row >= 4'h2);
                    next_mv    = 13'd1050 + 13'(row) * 13'd25 + ((row >= 4'h8) ? 13'd5 : 13'd0);
                end
                2'b10: begin
                    next_mv = 13'd1455 + 13'(row) * 13'd25 + ((row >= 4'h5) ? 13'd5 : 13'd0);
                end
                2'b11: begin
                    case (row)
                        4'h0:    next_mv = 13'd1860;
                        4'h1:    next_mv = 13'd1890;
                        4'hE:    next_mv = 13'd2200;
                        4'hF:    next_mv = 13'd2245;
                        default: next_mv = 13'd1865 + 13'(row) * 13'd25;
                    endcase
                end
                default: begin
                    next_avail = 1'b0;
                end
            endcase
            if (!next_avail) begin
                next_mv = 13'h0000;
            end
        end
    end

    // registered result
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_mv    <= 13'h0000;
            level_avail <= 1'b0;
        end else begin
            level_mv    <= next_mv;
            level_avail <= next_avail;
        end
    end

endmodule

`default_nettype wire

// ==== bkc_chk.sv ====
// assertion checker for the buck control block
`timescale 1ns/1ps
`default_nettype none

module bkc_chk (
    // clock and reset
    input wire logic                hclk,
    input wire logic                hresetn,
    // bus
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic                hreadyout,
    // converter
    input wire bkc_pkg::bkc_req_t   req_pins,
    input wire logic [6:0]          duty_demand,
    input wire logic                light_load,
    input wire logic                converter_enable,
    input wire logic [12:0]         target_mv,
    input wire logic                forced_pwm,
    input wire logic                psave_active,
    input wire bkc_pkg::bkc_drive_t drive
);
    // --------
    // timebase gap counter
    // --------
    logic [4:0] gap;
    logic       seen;
    // pulses only count as a period while switching at fixed frequency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap  <= 5'h00;
            seen <= 1'b0;
        end else begin
            gap  <= drive.cycle_start ? 5'h00 : gap + 5'h01;
            seen <= converter_enable & !psave_active & (seen | drive.cycle_start);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_take(w);
        hsel && htrans[1] && hready && (hwrite == w);
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    a_read_wait: assert property (s_take(1'b0) |=> s_one_wait)
        else $error("read data phase not one wait state");
    a_write_zero: assert property (s_take(1'b1) |=> hreadyout)
        else $error("write data phase stalled");
    a_req_off: assert property (!(|req_pins) ##1 !(|req_pins) |=> !converter_enable)
        else $error("converter on with no request");
    a_off_zero: assert property (!converter_enable |-> target_mv == 13'h0000)
        else $error("target nonzero while off");
    a_ramp_mono: assert property (converter_enable && $past(converter_enable)
        |-> target_mv >= $past(target_mv))
        else $error("target fell while enabled");
    a_mode_nosave: assert property (forced_pwm |-> !psave_active)
        else $error("power save while forced");
    a_psave_cause: assert property (psave_active |-> $past(light_load) && !forced_pwm)
        else $error("power save without light load");
    a_full_duty: assert property (converter_enable && $past(converter_enable)
        && !psave_active && !$past(psave_active) && $past(duty_demand) >= 7'h7D
        |-> drive.high_side_on)
        else $error("high side off at full duty");
    a_tb_period: assert property (drive.cycle_start && seen |-> gap inside {5'h0E, 5'h0F})
        else $error("timebase period wrong");
    a_tb_gap: assert property (seen |-> gap < 5'h10)
        else $error("timebase pulse missing");
endmodule

bind bkc_buck_ctrl bkc_chk chk_u (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .req_pins,
    .duty_demand, .light_load, .converter_enable, .target_mv, .forced_pwm,
    .psave_active, .drive
);

`default_nettype wire

// ==== bkc_host.sv ====
// bus master model standing in for the system processor
`timescale 1ns/1ps
`default_nettype none

module bkc_host (
    // clock
    input  wire logic        hclk,
    // bus
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    // idle bus at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // host register access, read or write
    // single word transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        // stale data is inverted so a late sampler sees garbage
        hwdata <= ~wd;
    endtask
endmodule

`default_nettype wire

// ==== buck_converter_control_bench.sv ====
// self-checking bench for the buck control block
`timescale 1ns/1ps
`default_nettype none
`include "bkc_cfg.svh"

module buck_converter_control_bench;
    localparam int SS = 20;
    logic hclk = 1'b0, hresetn = 1'b0, rnd = 1'b1;
    logic hsel, hwrite, hreadyout, hresp, pg_comp_raw = 1'b1;
    logic light_load = 1'b0, pfm_burst_request = 1'b0;
    logic converter_enable, forced_pwm, psave_active, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [6:0] duty_demand = 7'h00, v;
    logic [12:0] target_mv, pg_threshold_mv;
    logic [31:0] haddr, hwdata, hrdata, d;
    bkc_pkg::bkc_req_t req_pins = '0;
    bkc_pkg::bkc_drive_t drive;
    int err_total = 0, checks = 0;
    logic [6:0] corner [3] = '{7'h12, 7'h3F, 7'h7F};

    bkc_buck_ctrl #(.SS_CYCLES(SS), .VSEL_RST(7'h4B)) dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
        .hwdata, .hrdata, .hreadyout, .hresp, .req_pins, .pg_comp_raw, .duty_demand,
        .light_load, .pfm_burst_request, .converter_enable, .target_mv, .pg_threshold_mv,
        .forced_pwm, .psave_active, .drive, .irq
    );
    bkc_host host_u (
        .hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata
    );

    always #20 hclk = ~hclk;

    // random load conditions while rnd is set, then a light full-duty load
    always @(posedge hclk) begin
        duty_demand       <= rnd ? 7'($urandom_range(0, 127)) : 7'h7F;
        light_load        <= rnd ? 1'($urandom_range(0, 1)) : 1'b1;
        if (rnd) begin
            pfm_burst_request <= 1'($urandom_range(0, 1));
        end
    end

    // expected level: range 1 is linear, range 0 only at its end points
    function automatic logic [12:0] exp_mv(input logic [6:0] c);
        if (c[6]) return 13'h4E2 + 13'h32 * c[5:0];
        return (c[5:0] == 6'h12) ? 13'h44C : 13'h8C5;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        host_u.xfer(1'b1, a, w, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        host_u.xfer(1'b0, a, 32'h0, d);
        chk(d, e);
        chk(32'(hresp), 32'h0);
    endtask
    task automatic test_done;
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        test_done;
    end

    initial begin
        void'($urandom(68));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(`BKC_IDX_VSEL, 32'h4B);
        rdc(`BKC_IDX_CTRL, 32'h1);
        wr(`BKC_IDX_MODE, 32'hFF);
        rdc(`BKC_IDX_MODE, 32'h1);
        wr(`BKC_IDX_SPARE, 32'hFF);
        rdc(`BKC_IDX_SPARE, 32'h0);
        wr(8'h20, 32'hFF);
        rdc(8'h20, 32'h0);
        wr(`BKC_IDX_MODE, 32'h0);
        // each request pin, random and corner codes
        for (int i = 0; i < 6; i++) begin
            v = (i < 3) ? {1'b1, 6'($urandom_range(0, 63))} : corner[i-3];
            wr(`BKC_IDX_VSEL, {25'h0, v});
            rdc(`BKC_IDX_VSEL, {25'h0, v});
            req_pins <= bkc_pkg::bkc_req_t'(3'h1 << (i % 3));
            repeat (SS / 2) @(posedge hclk);
            chk(32'(converter_enable), 32'h1);
            chk(32'(target_mv > 0 && target_mv < exp_mv(v)), 32'h1);
            rdc(`BKC_IDX_CTRL, 32'h1);
            repeat (SS) @(posedge hclk);
            chk(32'(target_mv), 32'(exp_mv(v)));
            chk(32'(pg_threshold_mv), (exp_mv(v) * `BKC_PG_NUM) >> `BKC_PG_SHIFT);
            rdc(`BKC_IDX_CTRL, 32'h3);
            req_pins <= '0;
            repeat (3) @(posedge hclk);
            chk(32'(converter_enable), 32'h0);
        end
        req_pins <= 3'h7;
        wr(`BKC_IDX_CTRL, 32'h0);
        repeat (3) @(posedge hclk);
        chk(32'(converter_enable), 32'h0);
        wr(`BKC_IDX_CTRL, 32'h3);
        repeat (SS + 4) @(posedge hclk);
        chk(32'(converter_enable), 32'h1);
        pg_comp_raw <= 1'b0;
        repeat (4) @(posedge hclk);
        rdc(`BKC_IDX_CTRL, 32'h1);
        pg_comp_raw <= 1'b1;
        rnd <= 1'b0;
        @(posedge hclk);
        repeat (3) @(posedge hclk);
        chk(32'(psave_active), 32'h1);
        wr(`BKC_IDX_MODE, 32'h1);
        repeat (3) @(posedge hclk);
        chk(32'({forced_pwm, psave_active}), 32'h2);
        // high side held through a whole period
        repeat (16) begin
            @(posedge hclk);
            chk(32'({drive.high_side_on, drive.low_side_on}), 32'h2);
        end
        // unavailable code: flagged, stored, level kept
        host_u.xfer(1'b0, `BKC_IDX_IRQ_STAT, 32'h0, d);
        wr(`BKC_IDX_IRQ_MASK, 32'h8);
        wr(`BKC_IDX_VSEL, 32'h05);
        repeat (5) @(posedge hclk);
        chk(32'({irq, target_mv}), 32'(exp_mv(7'h7F)) | 32'h2000);
        rdc(`BKC_IDX_VSEL, 32'h05);
        rdc(`BKC_IDX_IRQ_STAT, 32'h8);
        rdc(`BKC_IDX_IRQ_STAT, 32'h0);
        chk(32'(irq), 32'h0);
        wr(`BKC_IDX_IRQ_MASK, 32'h0);
        wr(`BKC_IDX_VSEL, 32'h06);
        repeat (5) @(posedge hclk);
        chk(32'(irq), 32'h0);
        rdc(`BKC_IDX_IRQ_STAT, 32'h8);
        test_done;
    end
endmodule

`default_nettype wire
